// ### shared/lcd_port_pkg.sv
// constants and types shared by the lcd host bus port
// ==========================================================
// Notes on behaviour
// - parallel mode: 8-bit two-way data port
// - serial: data on bit 7, clock bit 6
// - serial: bits 0 to 5 never driven
// - chip not selected: all data lines released
// - selector high means display data, low command
// - reset low returns port to defaults
// - both selects needed to accept any transfer
// - separate strobes: drive only while read low
// - enable style: strobe high frames each cycle
// - separate strobes: write taken at rising edge
// - enable style: direction line high reads
// - interface strap high parallel, low serial
// - serial is write only, no reads
package lcd_port_pkg;
   // ==========================================================
   // bus geometry
   localparam int BYTE_BITS = 8;
   localparam int SERIAL_DATA_BIT = 7;
   localparam int SERIAL_CLK_BIT = 6;
   localparam int SYNC_STAGES = 2;
   localparam int BIT_CNT_W = 3;
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;
   localparam logic [2:0] BIT_CNT_RESET = 3'h0;
   // ==========================================================
   // strap and pin levels
   localparam logic STRAP_PARALLEL = 1'h1;
   localparam logic STYLE_ENABLE = 1'h1;
   localparam logic SELECT_DISPLAY_DATA = 1'h1;
   localparam logic DIR_READ = 1'h1;
   // ==========================================================
   // reset values and the full drive enable
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] OE_NONE = 8'h00;
   localparam logic [7:0] OE_ALL = 8'hff;
   // ==========================================================
   // modes
   typedef enum logic [1:0] {
      MODE_SEPARATE,
      MODE_ENABLE,
      MODE_SERIAL
   } bus_mode_e;
endpackage

// ### sim/host_model.sv
// host processor model on the far side of the lcd port
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic core_clk,
   input wire logic [7:0] data_out,
   input wire logic [7:0] data_oe,
   output logic [7:0] data_in,
   output logic chip_select_a_n,
   output logic chip_select_b,
   output logic cmd_data_select,
   output logic read_strobe_pin,
   output logic write_strobe_pin
);
   // ==========================================
   // pins and bus cycles
   logic [7:0] drv = 8'h00;
   // no pull resistors: a released line shows the host's own drive value drv
   assign data_in = (data_oe & data_out) | (~data_oe & drv);
   initial set(1'h1, 1'h1, 1'h0);
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic set(input logic a, input logic b, input logic style);
      chip_select_a_n = !a;
      chip_select_b = b;
      cmd_data_select = 1'h0;
      read_strobe_pin = !style; // idle strobes fixed
      write_strobe_pin = 1'h1;
   endtask
   task automatic wr(input logic style, input logic [7:0] b, input logic cls);
      drv = b;
      cmd_data_select = cls;
      write_strobe_pin = 1'h0;
      hold(1);
      read_strobe_pin = 1'h1;
      hold(4);
      read_strobe_pin = !style;
      write_strobe_pin = !style;
      hold(4);
      write_strobe_pin = 1'h1;
      drv = ~b;
      hold(4);
   endtask
   task automatic rd_begin(input logic style, input logic cls);
      cmd_data_select = cls;
      drv = drv ^ 8'hbf; // serial clock line left alone
      write_strobe_pin = 1'h1;
      read_strobe_pin = style;
   endtask
   // serial clock stands low between frames, 12 ns period inside
   task automatic ser(input logic [7:0] b, input logic cls, input int n);
      cmd_data_select = cls;
      drv[5:0] = ~drv[5:0];
      drv[6] = 1'h0; // clock low before the first edge
      for (int i = 7; i > 7 - n; i--)
      begin
         drv[7] = b[i];
         #3 drv[6] = 1'h1;
         #6 drv[6] = 1'h0;
         #3;
      end
      hold(6);
   endtask
endmodule
`default_nettype wire

// ### sim/lcd_port_props.sv
// concurrent checks on the pins of the lcd host bus port
`timescale 1ns/100ps
`default_nettype none
module lcd_port_props (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic reset_n_in,
   input wire logic chip_select_a_n,
   input wire logic chip_select_b,
   input wire logic read_strobe_pin,
   input wire logic write_strobe_pin,
   input wire logic [7:0] data_oe,
   input wire logic rd_req,
   input wire logic rx_valid,
   input wire logic [1:0] bus_mode
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // pin rules
   property p_oe_whole; data_oe == 8'h00 || data_oe == 8'hff; endproperty
   a_oe_whole: assert property (p_oe_whole) else $error("data enables split");
   property p_serial_quiet; bus_mode == 2'h2 |-> data_oe == 8'h00; endproperty
   a_serial_quiet: assert property (p_serial_quiet) else $error("serial drive");
   property p_deselect; (chip_select_a_n || !chip_select_b) [*4] |-> data_oe == 8'h00; endproperty
   a_deselect: assert property (p_deselect) else $error("drive while deselected");
   property p_reset_pin; !reset_n_in [*4] |-> data_oe == 8'h00 && !rx_valid && !rd_req; endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("activity in reset");
   property p_rd_pulse; rd_req |=> !rd_req; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse long");
   property p_oe_from_read; $rose(data_oe[0]) && bus_mode == 2'h0 |-> !$past(read_strobe_pin, 2); endproperty
   a_oe_from_read: assert property (p_oe_from_read) else $error("drive without read");
   property p_sep_write;
      rx_valid && bus_mode == 2'h0 |-> $past(write_strobe_pin, 2) && !$past(write_strobe_pin, 4) ##1 !rx_valid;
   endproperty
   a_sep_write: assert property (p_sep_write) else $error("byte without strobe rise");
   property p_enable_write;
      rx_valid && bus_mode == 2'h1 |-> !$past(write_strobe_pin, 3) && !$past(read_strobe_pin, 1);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("byte without enable frame");
   c_serial_rx: cover property (rx_valid && bus_mode == 2'h2);
   c_read: cover property (rd_req);
   c_enable_rx: cover property (rx_valid && bus_mode == 2'h1);
endmodule
bind lcd_driver_host_bus_port lcd_port_props props (.core_clk(core_clk), .rstn(rstn), .reset_n_in(reset_n_in),
   .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b), .read_strobe_pin(read_strobe_pin),
   .write_strobe_pin(write_strobe_pin), .data_oe(data_oe), .rd_req(rd_req), .rx_valid(rx_valid), .bus_mode(bus_mode));
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the lcd host bus port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic core_clk;
   logic rstn;
   logic reset_n_in;
   logic interface_strap;
   logic bus_style_select;
   logic [7:0] rd_data;
   logic rd_cls;
   logic chip_select_a_n, chip_select_b, cmd_data_select, read_strobe_pin, write_strobe_pin;
   logic rd_req, rd_is_data, rx_valid, rx_is_data;
   logic [7:0] data_in, data_out, data_oe, rx_data;
   logic [1:0] bus_mode;
   logic [7:0] rx_count = 8'h00;
   logic [7:0] rd_count = 8'h00;
   logic [7:0] n_rx = 8'h00;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   always #12.5 core_clk = ~core_clk;
   // ==========================================
   // pulse counters and hang guard
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      rx_count <= rx_count + {7'h00, rx_valid};
      rd_count <= rd_count + {7'h00, rd_req};
      if (cycles == 3000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   lcd_driver_host_bus_port dut (.core_clk(core_clk), .rstn(rstn), .serial_clk(data_in[6]), .reset_n_in(reset_n_in),
      .interface_strap(interface_strap), .bus_style_select(bus_style_select), .chip_select_a_n(chip_select_a_n),
      .chip_select_b(chip_select_b), .cmd_data_select(cmd_data_select), .read_strobe_pin(read_strobe_pin),
      .write_strobe_pin(write_strobe_pin), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .rd_data(rd_data), .rd_req(rd_req), .rd_is_data(rd_is_data), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_is_data(rx_is_data), .bus_mode(bus_mode));
   host_model host (.core_clk(core_clk), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
      .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b), .cmd_data_select(cmd_data_select),
      .read_strobe_pin(read_strobe_pin), .write_strobe_pin(write_strobe_pin));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      if (seen !== exp)
         err_count++;
   endtask
   task automatic got(input logic [7:0] exp, input logic cls);
      n_rx++;
      check(rx_count, n_rx);
      check(rx_data, exp);
      check({7'h00, rx_is_data}, {7'h00, cls});
   endtask
   task automatic rd_check(input logic style, input logic [7:0] v, input logic [7:0] oe);
      rd_data = v;
      host.rd_begin(style, style);
      host.hold(5);
      check(data_oe, oe);
      check(data_out & oe, v & oe);
      if (oe != 8'h00)
         rd_cls = style;
      check({7'h00, rd_is_data}, {7'h00, rd_cls});
      host.set(1'h1, 1'h1, style);
      host.hold(5);
      check(data_oe, 8'h00);
   endtask
   // change of mode only while deselected, so no stray strobe edge lands
   task automatic mode(input logic strap, input logic style, input logic [7:0] m);
      host.set(1'h0, 1'h0, style);
      interface_strap = strap;
      bus_style_select = style;
      host.hold(5);
      host.set(1'h1, 1'h1, style);
      check({6'h00, bus_mode}, m);
   endtask
   task automatic t_separate;
      mode(1'h1, 1'h0, 8'h00);
      host.wr(1'h0, 8'ha5, 1'h0);
      got(8'ha5, 1'h0);
      rd_check(1'h0, 8'h3c, 8'hff);
      check(rd_count, 8'h01);
      host.set(1'h1, 1'h0, 1'h0);
      host.wr(1'h0, 8'h77, 1'h1);
      rd_check(1'h0, 8'h55, 8'h00);
      check(rx_count, n_rx);
   endtask
   task automatic t_enable;
      mode(1'h1, 1'h1, 8'h01);
      host.wr(1'h1, 8'h5a, 1'h1);
      got(8'h5a, 1'h1);
      rd_check(1'h1, 8'he1, 8'hff);
   endtask
   task automatic t_serial;
      mode(1'h0, 1'h0, 8'h02);
      host.ser(8'h96, 1'h1, 8);
      got(8'h96, 1'h1);
      host.ser(8'h01, 1'h0, 8);
      got(8'h01, 1'h0);
      host.ser(8'hff, 1'h1, 3);
      host.set(1'h0, 1'h1, 1'h0);
      host.hold(4);
      host.set(1'h1, 1'h1, 1'h0);
      host.ser(8'h4b, 1'h0, 8);
      got(8'h4b, 1'h0);
      rd_check(1'h0, 8'h99, 8'h00);
      check(rd_count, 8'h02);
   endtask
   task automatic t_reset_pin;
      mode(1'h1, 1'h0, 8'h00);
      reset_n_in = 1'h0;
      host.wr(1'h0, 8'h33, 1'h1);
      check(rx_count, n_rx);
      check(rx_data, 8'h00);
      reset_n_in = 1'h1;
      host.hold(5);
      host.wr(1'h0, 8'hc6, 1'h1);
      got(8'hc6, 1'h1);
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      core_clk = 1'h0;
      rstn = 1'h0;
      reset_n_in = 1'h0;
      interface_strap = 1'h1;
      bus_style_select = 1'h0;
      rd_data = 8'h00;
      rd_cls = 1'h0;
      repeat (19) @(posedge core_clk);
      #1;
      check({6'h00, bus_mode} | data_oe | rx_data, 8'h00);
      host.hold(1);
      rstn = 1'h1;
      reset_n_in = 1'h1;
      host.hold(6);
      t_separate;
      t_enable;
      t_serial;
      t_reset_pin;
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ### verilog/lcd_driver_host_bus_port.sv
// host bus port: parallel (two styles) and write-only serial
`timescale 1ns/100ps
`default_nettype none
module lcd_driver_host_bus_port (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic serial_clk,
   input wire logic reset_n_in,
   input wire logic interface_strap,
   input wire logic bus_style_select,
   input wire logic chip_select_a_n,
   input wire logic chip_select_b,
   input wire logic cmd_data_select,
   input wire logic read_strobe_pin,
   input wire logic write_strobe_pin,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic [7:0] data_oe,
   input wire logic [7:0] rd_data,
   output logic rd_req,
   output logic rd_is_data,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_is_data,
   output logic [1:0] bus_mode
);
   // ==========================================================
   // pin synchronisers
   localparam int PIN_W = 16;
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_s;
   logic s_reset_n;
   logic s_strap;
   logic s_style;
   logic s_dc;
   logic s_cs_a_n;
   logic s_cs_b;
   logic s_rd;
   logic s_wr;
   logic [7:0] s_data;

   assign pins_raw = {reset_n_in, interface_strap, bus_style_select, cmd_data_select,
                      chip_select_a_n, chip_select_b, read_strobe_pin, write_strobe_pin, data_in};

   pin_sync #(.WIDTH(PIN_W)) u_pin_sync (
      .clk(core_clk),
      .rstn(rstn),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   assign s_reset_n = pins_s[15];
   assign s_strap = pins_s[14];
   assign s_style = pins_s[13];
   assign s_dc = pins_s[12];
   assign s_cs_a_n = pins_s[11];
   assign s_cs_b = pins_s[10];
   assign s_rd = pins_s[9];
   assign s_wr = pins_s[8];
   assign s_data = pins_s[7:0];

   // ==========================================================
   // mode decode
   lcd_port_pkg::bus_mode_e mode_q;
   logic [2:0] settle_q; // syncs wake at 0, so early strobe edges are false
   logic cs_ok;

   assign cs_ok = !s_cs_a_n && s_cs_b && settle_q[2];

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_q <= lcd_port_pkg::MODE_SEPARATE;
      end
      else if (s_strap != lcd_port_pkg::STRAP_PARALLEL)
      begin
         mode_q <= lcd_port_pkg::MODE_SERIAL;
      end
      else if (s_style == lcd_port_pkg::STYLE_ENABLE)
      begin
         mode_q <= lcd_port_pkg::MODE_ENABLE;
      end
      else
      begin
         mode_q <= lcd_port_pkg::MODE_SEPARATE;
      end
   end

   // ==========================================================
   // strobe history for edge detection
   logic rd_prev_q;
   logic wr_prev_q;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_prev_q <= 1'b1;
         wr_prev_q <= 1'b1;
         settle_q <= 3'h0;
      end
      else
      begin
         rd_prev_q <= s_rd;
         wr_prev_q <= s_wr;
         settle_q <= {settle_q[1:0], 1'b1};
      end
   end

   // ==========================================================
   // parallel event decode
   logic par_write;
   logic par_read_start;
   logic par_read_active;

   always_comb
   begin
      par_write = 1'b0;
      par_read_start = 1'b0;
      par_read_active = 1'b0;
      unique case (mode_q)
         lcd_port_pkg::MODE_SEPARATE:
         begin
            par_write = cs_ok && !wr_prev_q && s_wr;
            par_read_start = cs_ok && rd_prev_q && !s_rd;
            par_read_active = cs_ok && !s_rd;
         end
         lcd_port_pkg::MODE_ENABLE:
         begin
            // write closes on the falling edge of the enable
            par_write = cs_ok && rd_prev_q && !s_rd && (s_wr != lcd_port_pkg::DIR_READ);
            par_read_start = cs_ok && !rd_prev_q && s_rd && (s_wr == lcd_port_pkg::DIR_READ);
            par_read_active = cs_ok && s_rd && (s_wr == lcd_port_pkg::DIR_READ);
         end
         lcd_port_pkg::MODE_SERIAL:
         begin
            // strobe pins are tied off, nothing to decode
            par_write = 1'b0;
            par_read_start = 1'b0;
            par_read_active = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // serial shifter on the link clock
   logic serial_rst_n;
   logic [2:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic [7:0] ser_byte_q;
   logic ser_dc_q;
   logic ser_toggle_q;

   // frame ends by deselect; the shifter restarts clean at the next frame
   assign serial_rst_n = rstn && reset_n_in && !chip_select_a_n && chip_select_b
                         && (interface_strap != lcd_port_pkg::STRAP_PARALLEL);

   always_ff @(posedge serial_clk or negedge serial_rst_n)
   begin
      if (!serial_rst_n)
      begin
         bit_cnt_q <= lcd_port_pkg::BIT_CNT_RESET;
         shift_q <= 7'h00;
      end
      else
      begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shift_q <= {shift_q[5:0], data_in[lcd_port_pkg::SERIAL_DATA_BIT]};
      end
   end

   // held byte survives the deselect so the core can still pick it up
   always_ff @(posedge serial_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ser_byte_q <= lcd_port_pkg::BYTE_RESET;
         ser_dc_q <= 1'b0;
         ser_toggle_q <= 1'b0;
      end
      else if (serial_rst_n && bit_cnt_q == lcd_port_pkg::BIT_CNT_LAST)
      begin
         ser_byte_q <= {shift_q, data_in[lcd_port_pkg::SERIAL_DATA_BIT]};
         ser_dc_q <= cmd_data_select;
         ser_toggle_q <= ~ser_toggle_q;
      end
   end

   // ==========================================================
   // serial byte crossing into core clock
   logic toggle_s;
   logic toggle_seen_q;
   logic ser_event;

   pin_sync #(.WIDTH(1)) u_toggle_sync (
      .clk(core_clk),
      .rstn(rstn),
      .async_in(ser_toggle_q),
      .sync_out(toggle_s)
   );

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         toggle_seen_q <= 1'b0;
      end
      else
      begin
         toggle_seen_q <= toggle_s;
      end
   end

   // held byte is stable for eight link clocks, well past the crossing delay
   assign ser_event = (toggle_s != toggle_seen_q) && (mode_q == lcd_port_pkg::MODE_SERIAL);

   // ==========================================================
   // received transfers toward the controller
   logic rx_valid_q;
   logic [7:0] rx_data_q;
   logic rx_is_data_q;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_valid_q <= 1'b0;
         rx_data_q <= lcd_port_pkg::BYTE_RESET;
         rx_is_data_q <= 1'b0;
      end
      else if (!s_reset_n)
      begin
         rx_valid_q <= 1'b0;
         rx_data_q <= lcd_port_pkg::BYTE_RESET;
         rx_is_data_q <= 1'b0;
      end
      else if (ser_event)
      begin
         rx_valid_q <= 1'b1;
         rx_data_q <= ser_byte_q;
         rx_is_data_q <= (ser_dc_q == lcd_port_pkg::SELECT_DISPLAY_DATA);
      end
      else if (par_write)
      begin
         rx_valid_q <= 1'b1;
         rx_data_q <= s_data;
         rx_is_data_q <= (s_dc == lcd_port_pkg::SELECT_DISPLAY_DATA);
      end
      else
      begin
         rx_valid_q <= 1'b0;
      end
   end

   // ==========================================================
   // read request toward the controller
   logic rd_req_q;
   logic rd_is_data_q;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_req_q <= 1'b0;
         rd_is_data_q <= 1'b0;
      end
      else if (!s_reset_n)
      begin
         rd_req_q <= 1'b0;
         rd_is_data_q <= 1'b0;
      end
      else
      begin
         rd_req_q <= par_read_start;
         if (par_read_start)
         begin
            rd_is_data_q <= (s_dc == lcd_port_pkg::SELECT_DISPLAY_DATA);
         end
      end
   end

   // ==========================================================
   // data pin drivers
   // drive lags the strobe by the sync delay; host must allow for it
   logic [7:0] data_out_q;
   logic [7:0] data_oe_q;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         data_out_q <= lcd_port_pkg::BYTE_RESET;
         data_oe_q <= lcd_port_pkg::OE_NONE;
      end
      else if (!s_reset_n || !cs_ok)
      begin
         data_oe_q <= lcd_port_pkg::OE_NONE;
      end
      else if (mode_q == lcd_port_pkg::MODE_SERIAL)
      begin
         data_oe_q <= lcd_port_pkg::OE_NONE;
      end
      else if (par_read_active)
      begin
         data_out_q <= rd_data;
         data_oe_q <= lcd_port_pkg::OE_ALL;
      end
      else
      begin
         data_oe_q <= lcd_port_pkg::OE_NONE;
      end
   end

   // ==========================================================
   // outputs
   logic [1:0] bus_mode_q;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bus_mode_q <= 2'h0;
      end
      else
      begin
         bus_mode_q <= mode_q;
      end
   end

   assign data_out = data_out_q;
   assign data_oe = data_oe_q;
   assign rd_req = rd_req_q;
   assign rd_is_data = rd_is_data_q;
   assign rx_valid = rx_valid_q;
   assign rx_data = rx_data_q;
   assign rx_is_data = rx_is_data_q;
   assign bus_mode = bus_mode_q;
endmodule
`default_nettype wire

// ### verilog/pin_sync.sv
// two-flop synchroniser, one chain per bit
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // ==========================================================
   // per bit chains
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic meta_q;
         logic stable_q;
         // first stage feeds only the second
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               meta_q <= 1'b0;
               stable_q <= 1'b0;
            end
            else
            begin
               meta_q <= async_in[i];
               stable_q <= meta_q;
            end
         end
         assign sync_out[i] = stable_q;
      end
   endgenerate
endmodule
`default_nettype wire
